/* rtl/fpim_flash_irq.sv */
module fpim_flash_irq
    import fpim_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    // Flash bank pins: clk, select, data0..data3
    input  wire logic [NUM_PINS-1:0] pin_level_in,
    // APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [BUS_W-1:0]  pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic      [BUS_W-1:0]  prdata_out,
    // Interrupt lines
    output logic                   core0_irq_out,
    output logic                   core1_irq_out,
    output logic                   wake_irq_out
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] level_d_ff;
    logic [EV_BITS-1:0]  edge_ff;
    logic [EV_BITS-1:0]  nxt_edge;
    logic [EV_BITS-1:0]  raw_pin_events;
    logic [EV_BITS-1:0]  core0_irq_enable_mask_ff;
    logic [EV_BITS-1:0]  core0_irq_force_ff;
    logic [EV_BITS-1:0]  core1_irq_enable_mask_ff;
    logic [EV_BITS-1:0]  core1_irq_force_ff;
    logic [EV_BITS-1:0]  wake_irq_enable_mask_ff;
    logic [EV_BITS-1:0]  nxt_c0_en;
    logic [EV_BITS-1:0]  nxt_c0_frc;
    logic [EV_BITS-1:0]  nxt_c1_en;
    logic [EV_BITS-1:0]  nxt_c1_frc;
    logic [EV_BITS-1:0]  nxt_wake_en;
    logic [EV_BITS-1:0]  core0_masked_irq_status;
    logic [EV_BITS-1:0]  core1_masked_irq_status;
    logic [EV_BITS-1:0]  wake_status;
    logic [EV_BITS-1:0]  wdata_ev;
    logic [BUS_W-1:0]    nxt_prdata;
    logic                nxt_pready;
    logic                nxt_pslverr;
    logic                setup;
    logic                wr;

    // Byte-lane merge of a write into a 24-bit event register
    function automatic logic [EV_BITS-1:0] merge(input logic [EV_BITS-1:0] cur,
                                                 input logic [BUS_W-1:0]   wd,
                                                 input logic [3:0]         st);
        logic [EV_BITS-1:0] r;
        r = cur;
        for (int b = 0; b < EV_BITS / 8; b++)
        begin
            if (st[b])
            begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Address is one of the mapped registers
    function automatic logic mapped(input logic [7:0] a);
        return a == OFS_RAW_EVENTS || a == OFS_C0_ENABLE || a == OFS_C0_FORCE
            || a == OFS_C0_STATUS || a == OFS_C1_ENABLE || a == OFS_C1_FORCE
            || a == OFS_C1_STATUS || a == OFS_WAKE_ENABLE;
    endfunction

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    fpim_pin_sync #(
        .WIDTH     (NUM_PINS)
    ) u_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .pin_in    (pin_level_in),
        .level_out (level)
    );

    // APB request qualifiers; access phase lasts one cycle
    assign setup    = psel_in && !penable_in;
    assign wr       = psel_in && penable_in && pwrite_in;
    assign wdata_ev = merge(EV_RESET, pwdata_in, pstrb_in);

    // ------------------------------------------------------------
    // Raw events and masked status
    // ------------------------------------------------------------
    // Event nibbles per pin; edges sticky, set beats write-one clear
    always_comb
    begin
        nxt_edge       = edge_ff;
        raw_pin_events = edge_ff;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            raw_pin_events[p*EV_PER_PIN + EV_LEVEL_LOW]  = !level[p];
            raw_pin_events[p*EV_PER_PIN + EV_LEVEL_HIGH] = level[p];
            if (wr && paddr_in == OFS_RAW_EVENTS)
            begin
                nxt_edge[p*EV_PER_PIN + EV_EDGE_LOW]  =
                    edge_ff[p*EV_PER_PIN + EV_EDGE_LOW] & !wdata_ev[p*EV_PER_PIN + EV_EDGE_LOW];
                nxt_edge[p*EV_PER_PIN + EV_EDGE_HIGH] =
                    edge_ff[p*EV_PER_PIN + EV_EDGE_HIGH] & !wdata_ev[p*EV_PER_PIN + EV_EDGE_HIGH];
            end
            if (level_d_ff[p] && !level[p])
            begin
                nxt_edge[p*EV_PER_PIN + EV_EDGE_LOW] = 1'b1;
            end
            if (!level_d_ff[p] && level[p])
            begin
                nxt_edge[p*EV_PER_PIN + EV_EDGE_HIGH] = 1'b1;
            end
            nxt_edge[p*EV_PER_PIN + EV_LEVEL_LOW]  = 1'b0;
            nxt_edge[p*EV_PER_PIN + EV_LEVEL_HIGH] = 1'b0;
        end
        core0_masked_irq_status = (raw_pin_events & core0_irq_enable_mask_ff)
                                | core0_irq_force_ff;
        core1_masked_irq_status = (raw_pin_events & core1_irq_enable_mask_ff)
                                | core1_irq_force_ff;
        wake_status             = raw_pin_events & wake_irq_enable_mask_ff;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Enable and force next values
    always_comb
    begin
        nxt_c0_en   = core0_irq_enable_mask_ff;
        nxt_c0_frc  = core0_irq_force_ff;
        nxt_c1_en   = core1_irq_enable_mask_ff;
        nxt_c1_frc  = core1_irq_force_ff;
        nxt_wake_en = wake_irq_enable_mask_ff;
        if (wr)
        begin
            case (paddr_in)
                OFS_C0_ENABLE:   nxt_c0_en   = merge(core0_irq_enable_mask_ff, pwdata_in, pstrb_in);
                OFS_C0_FORCE:    nxt_c0_frc  = merge(core0_irq_force_ff, pwdata_in, pstrb_in);
                OFS_C1_ENABLE:   nxt_c1_en   = merge(core1_irq_enable_mask_ff, pwdata_in, pstrb_in);
                OFS_C1_FORCE:    nxt_c1_frc  = merge(core1_irq_force_ff, pwdata_in, pstrb_in);
                OFS_WAKE_ENABLE: nxt_wake_en = merge(wake_irq_enable_mask_ff, pwdata_in, pstrb_in);
                default:         nxt_c0_en   = core0_irq_enable_mask_ff;
            endcase
        end
    end

    // Read mux, reserved upper bits zero
    always_comb
    begin
        nxt_prdata  = prdata_out;
        nxt_pready  = setup;
        nxt_pslverr = setup && !mapped(paddr_in);
        if (setup && !pwrite_in)
        begin
            case (paddr_in)
                OFS_RAW_EVENTS:  nxt_prdata = {{RSVD_W{1'b0}}, raw_pin_events};
                OFS_C0_ENABLE:   nxt_prdata = {{RSVD_W{1'b0}}, core0_irq_enable_mask_ff};
                OFS_C0_FORCE:    nxt_prdata = {{RSVD_W{1'b0}}, core0_irq_force_ff};
                OFS_C0_STATUS:   nxt_prdata = {{RSVD_W{1'b0}}, core0_masked_irq_status};
                OFS_C1_ENABLE:   nxt_prdata = {{RSVD_W{1'b0}}, core1_irq_enable_mask_ff};
                OFS_C1_FORCE:    nxt_prdata = {{RSVD_W{1'b0}}, core1_irq_force_ff};
                OFS_C1_STATUS:   nxt_prdata = {{RSVD_W{1'b0}}, core1_masked_irq_status};
                OFS_WAKE_ENABLE: nxt_prdata = {{RSVD_W{1'b0}}, wake_irq_enable_mask_ff};
                default:         nxt_prdata = RD_ZERO;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            level_d_ff               <= '0;
            edge_ff                  <= EV_RESET;
            core0_irq_enable_mask_ff <= EV_RESET;
            core0_irq_force_ff       <= EV_RESET;
            core1_irq_enable_mask_ff <= EV_RESET;
            core1_irq_force_ff       <= EV_RESET;
            wake_irq_enable_mask_ff  <= EV_RESET;
            prdata_out               <= RD_ZERO;
            pready_out               <= 1'b0;
            pslverr_out              <= 1'b0;
            core0_irq_out            <= 1'b0;
            core1_irq_out            <= 1'b0;
            wake_irq_out             <= 1'b0;
        end
        else
        begin
            level_d_ff               <= level;
            edge_ff                  <= nxt_edge;
            core0_irq_enable_mask_ff <= nxt_c0_en;
            core0_irq_force_ff       <= nxt_c0_frc;
            core1_irq_enable_mask_ff <= nxt_c1_en;
            core1_irq_force_ff       <= nxt_c1_frc;
            wake_irq_enable_mask_ff  <= nxt_wake_en;
            prdata_out               <= nxt_prdata;
            pready_out               <= nxt_pready;
            pslverr_out              <= nxt_pslverr;
            core0_irq_out            <= |core0_masked_irq_status;
            core1_irq_out            <= |core1_masked_irq_status;
            wake_irq_out             <= |wake_status;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_C0_LINE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ##1 core0_irq_out == $past(|core0_masked_irq_status))
        else $error("core0 line does not follow status");
    AST_C1_LINE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (|core1_irq_force_ff) |=> core1_irq_out)
        else $error("core1 force did not raise line");
    AST_C0_FORCE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (setup && !pwrite_in && paddr_in == OFS_C0_STATUS)
        |=> (prdata_out[EV_BITS-1:0] & $past(core0_irq_force_ff)) == $past(core0_irq_force_ff))
        else $error("core0 force bit not in status read");
    AST_C1_MASK: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (setup && !pwrite_in && paddr_in == OFS_C1_STATUS)
        |=> (prdata_out[EV_BITS-1:0]
             & ~$past(core1_irq_force_ff | core1_irq_enable_mask_ff)) == '0)
        else $error("core1 status read set without enable");
    AST_C1_EN_WR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr && paddr_in == OFS_C1_ENABLE && pstrb_in == 4'hF)
        |=> core1_irq_enable_mask_ff == $past(pwdata_in[EV_BITS-1:0]))
        else $error("core1 enable write lost");
    AST_C1_FRC_WR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr && paddr_in == OFS_C1_FORCE && pstrb_in == 4'hF)
        |=> core1_irq_force_ff == $past(pwdata_in[EV_BITS-1:0]))
        else $error("core1 force write lost");
    AST_RSVD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        pready_out |-> prdata_out[BUS_W-1:EV_BITS] == '0)
        else $error("reserved bits read nonzero");
    AST_LEVEL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (setup && !pwrite_in && paddr_in == OFS_RAW_EVENTS)
        |=> prdata_out[EV_LEVEL_LOW] != prdata_out[EV_LEVEL_HIGH])
        else $error("clock pin level bits inconsistent in read");
    AST_EDGE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!level_d_ff[0] && level[0]) |=> edge_ff[EV_EDGE_HIGH])
        else $error("rising edge not latched");
    AST_WAKE_WR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr && paddr_in == OFS_WAKE_ENABLE && pstrb_in == 4'hF)
        |=> wake_irq_enable_mask_ff == $past(pwdata_in[EV_BITS-1:0]))
        else $error("wake enable write lost");
    AST_C0_WR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr && paddr_in == OFS_C0_FORCE && pstrb_in == 4'hF)
        |=> core0_irq_force_ff == $past(pwdata_in[EV_BITS-1:0]))
        else $error("core0 force write lost");
endmodule // fpim_flash_irq

/* common/fpim_pkg.sv */
package fpim_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RAW_EVENTS   = 8'h30;
    localparam logic [7:0] OFS_C0_ENABLE    = 8'h34;
    localparam logic [7:0] OFS_C0_FORCE     = 8'h38;
    localparam logic [7:0] OFS_C0_STATUS    = 8'h3C;
    localparam logic [7:0] OFS_C1_ENABLE    = 8'h40;
    localparam logic [7:0] OFS_C1_FORCE     = 8'h44;
    localparam logic [7:0] OFS_C1_STATUS    = 8'h48;
    localparam logic [7:0] OFS_WAKE_ENABLE  = 8'h4C;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int         NUM_PINS         = 6;
    localparam int         EV_PER_PIN       = 4;
    localparam int         EV_BITS          = NUM_PINS * EV_PER_PIN;
    localparam int         EV_LEVEL_LOW     = 0;
    localparam int         EV_LEVEL_HIGH    = 1;
    localparam int         EV_EDGE_LOW      = 2;
    localparam int         EV_EDGE_HIGH     = 3;
    localparam int         BUS_W            = 32;
    localparam int         RSVD_W           = BUS_W - EV_BITS;
    localparam logic [EV_BITS-1:0] EV_RESET = 24'h000000;
    localparam logic [BUS_W-1:0]   RD_ZERO  = 32'h00000000;
endpackage

/* rtl/fpim_pin_sync.sv */
// ------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------
module fpim_pin_sync
    import fpim_pkg::*;
#(
    parameter int WIDTH = 6
)
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    // Asynchronous pins and filtered level
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] nxt_level;

    // Level moves only when the second and third stages agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s2_ff[i] : level_out[i];
        end
    end

    // Synchroniser stages
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_ff     <= '0;
            s2_ff     <= '0;
            s3_ff     <= '0;
            level_out <= '0;
        end
        else
        begin
            s1_ff     <= pin_in;
            s2_ff     <= s1_ff;
            s3_ff     <= s2_ff;
            level_out <= nxt_level;
        end
    end
endmodule // fpim_pin_sync

/* tb/fpim_apb_master.sv */
// ------------------------------------------------------------
// APB master standing in for the processor cores
// ------------------------------------------------------------
module fpim_apb_master
    import fpim_pkg::*;
(
    // Clock
    input  wire logic             clk_in,
    // APB request
    output logic                  psel_out,
    output logic                  penable_out,
    output logic                  pwrite_out,
    output logic      [7:0]       paddr_out,
    output logic      [BUS_W-1:0] pwdata_out,
    // APB answer
    input  wire logic             pready_in,
    input  wire logic             pslverr_in,
    input  wire logic [BUS_W-1:0] prdata_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'h00;
        pwdata_out  = 32'h00000000;
    end

    // One transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [BUS_W-1:0] wd,
                        output logic [BUS_W-1:0] rd, output logic err);
        psel_out    <= 1'b1;
        pwrite_out  <= wr;
        paddr_out   <= a;
        pwdata_out  <= wd;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        rd = prdata_in;
        err = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        // Idle edge so the next setup never collides with this release
        @(posedge clk_in);
    endtask
endmodule // fpim_apb_master

/* tb/flash_pin_irq_mask_force_bench.sv */
module flash_pin_irq_mask_force_bench import fpim_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TIMEOUT_CYC = 5000;

    logic                clk_in    = 1'b0;
    logic                arst_n_in = 1'b0;
    logic [NUM_PINS-1:0] pins      = '0;
    logic                psel, penable, pwrite, pready, pslverr, irq0, irq1, irqw;
    logic [7:0]          paddr;
    logic [BUS_W-1:0]    pwdata, prdata, r, s0, s1;
    logic [EV_BITS-1:0]  en0, f0, en1, f1, wk, edg, clr;
    logic [NUM_PINS-1:0] nv;
    int                  failures = 0;
    int                  n_tests  = 0;
    int                  cyc      = 0;

    // ------------------------------------------------------------
    // Clock, timeout and instances
    // ------------------------------------------------------------
    always #12.5 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT_CYC)
        begin
            $display("BAD timeout expected %0d got %0d", TIMEOUT_CYC - 1, cyc);
            failures++;
            complete_run();
        end
    end

    fpim_apb_master u_fpim_apb_master (.clk_in(clk_in), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata));

    fpim_flash_irq u_fpim_flash_irq (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .pin_level_in(pins), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .pready_out(pready),
        .pslverr_out(pslverr), .prdata_out(prdata), .core0_irq_out(irq0),
        .core1_irq_out(irq1), .wake_irq_out(irqw));

    // ------------------------------------------------------------
    // Checking helpers and reference model
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [BUS_W-1:0] e, input logic [BUS_W-1:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("BAD %s expected %h got %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [BUS_W-1:0] e,
                        input logic ee);
        logic [BUS_W-1:0] d;
        logic             er;
        u_fpim_apb_master.xfer(1'b0, a, 32'h00000000, d, er);
        check(nm, e, d);
        check({nm, "_err"}, BUS_W'(ee), BUS_W'(er));
    endtask

    task automatic wr(input logic [7:0] a, input logic [BUS_W-1:0] v);
        logic [BUS_W-1:0] d;
        logic             er;
        u_fpim_apb_master.xfer(1'b1, a, v, d, er);
    endtask

    // Raw events: live level bits plus latched edge bits
    function automatic logic [BUS_W-1:0] raw_exp();
        logic [BUS_W-1:0] x;
        x = BUS_W'(edg);
        for (int p = 0; p < NUM_PINS; p++)
        begin
            x[EV_PER_PIN*p+EV_LEVEL_LOW]  = ~pins[p];
            x[EV_PER_PIN*p+EV_LEVEL_HIGH] = pins[p];
        end
        return x;
    endfunction

    // Reads every register and the three lines against the model
    task automatic read_all();
        r  = raw_exp();
        s0 = (r & BUS_W'(en0)) | BUS_W'(f0);
        s1 = (r & BUS_W'(en1)) | BUS_W'(f1);
        rchk("raw", OFS_RAW_EVENTS, r, 1'b0);
        rchk("c0_en", OFS_C0_ENABLE, BUS_W'(en0), 1'b0);
        rchk("c0_force", OFS_C0_FORCE, BUS_W'(f0), 1'b0);
        rchk("c0_status", OFS_C0_STATUS, s0, 1'b0);
        rchk("c1_en", OFS_C1_ENABLE, BUS_W'(en1), 1'b0);
        rchk("c1_force", OFS_C1_FORCE, BUS_W'(f1), 1'b0);
        rchk("c1_status", OFS_C1_STATUS, s1, 1'b0);
        rchk("wake_en", OFS_WAKE_ENABLE, BUS_W'(wk), 1'b0);
        check("irq0", BUS_W'(|s0), BUS_W'(irq0));
        check("irq1", BUS_W'(|s1), BUS_W'(irq1));
        check("irq_wake", BUS_W'(|(r & BUS_W'(wk))), BUS_W'(irqw));
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {en0, f0, en1, f1, wk, edg} = '0;
        void'($urandom(19558));
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        // Reset values and unmapped places
        read_all();
        rchk("unmapped_50", 8'h50, 32'h00000000, 1'b1);
        rchk("unmapped_00", 8'h00, 32'h00000000, 1'b1);
        wr(8'h2C, 32'hFFFFFFFF);
        rchk("unmapped_2c", 8'h2C, 32'h00000000, 1'b1);
        $display("Test reset and map done");
        // Random masks, forces and pin traffic
        for (int i = 0; i < 24; i++)
        begin
            en0 = EV_BITS'($urandom);
            en1 = EV_BITS'($urandom);
            wk  = EV_BITS'($urandom);
            f0  = (i % 3 == 0) ? EV_BITS'($urandom) : EV_RESET;
            f1  = (i % 3 == 1) ? EV_BITS'($urandom) : EV_RESET;
            wr(OFS_C0_ENABLE, {8'hFF, en0});
            wr(OFS_C0_FORCE, {8'hA5, f0});
            wr(OFS_C1_ENABLE, {8'h5A, en1});
            wr(OFS_C1_FORCE, {8'hFF, f1});
            wr(OFS_WAKE_ENABLE, {8'hC3, wk});
            wr(OFS_C0_STATUS, $urandom);
            wr(OFS_C1_STATUS, $urandom);
            nv = NUM_PINS'($urandom);
            for (int p = 0; p < NUM_PINS; p++)
            begin
                if (pins[p] && !nv[p]) edg[EV_PER_PIN*p+EV_EDGE_LOW] = 1'b1;
                if (!pins[p] && nv[p]) edg[EV_PER_PIN*p+EV_EDGE_HIGH] = 1'b1;
            end
            pins <= nv;
            repeat (8) @(posedge clk_in);
            read_all();
            // Write-one-clear on edges, level bits untouched
            clr = EV_BITS'($urandom);
            wr(OFS_RAW_EVENTS, {8'hFF, clr});
            for (int p = 0; p < NUM_PINS; p++)
            begin
                edg[EV_PER_PIN*p+EV_EDGE_LOW]  &= ~clr[EV_PER_PIN*p+EV_EDGE_LOW];
                edg[EV_PER_PIN*p+EV_EDGE_HIGH] &= ~clr[EV_PER_PIN*p+EV_EDGE_HIGH];
            end
            rchk("raw_cleared", OFS_RAW_EVENTS, raw_exp(), 1'b0);
        end
        $display("Test random masks, forces and pins done");
        // Mid-run reset with pins low, written registers must clear
        pins <= '0;
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b0;
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        {en0, f0, en1, f1, wk, edg} = '0;
        repeat (6) @(posedge clk_in);
        read_all();
        $display("Test mid-run reset done");
        complete_run();
    end
endmodule // flash_pin_irq_mask_force_bench
